/* File: hw/tpe_pkg.sv */
// constants and types for the timer prescaler, edge selector and port block
package tpe_pkg;
   // register indices, byte address is four times the index
   localparam logic [15:0] IDX_MODE_CH1  = 16'hFFB7;
   localparam logic [15:0] IDX_MODE_CH0  = 16'hFFBB;
   localparam logic [15:0] IDX_CTRL      = 16'hFFC0;
   localparam logic [15:0] IDX_CMP_CH0   = 16'hFFC1;
   localparam logic [15:0] IDX_CMP_CH1   = 16'hFFC2;
   localparam logic [15:0] IDX_CNT_CH0   = 16'hFFC3;
   localparam logic [15:0] IDX_CNT_CH1   = 16'hFFC4;
   localparam logic [15:0] IDX_STATUS    = 16'hFFC5;
   localparam logic [15:0] IDX_PORT_DIR  = 16'hFFC6;
   localparam logic [15:0] IDX_PORT_LAT  = 16'hFFC7;
   localparam logic [17:0] A_MODE_CH1    = {IDX_MODE_CH1, 2'h0};
   localparam logic [17:0] A_MODE_CH0    = {IDX_MODE_CH0, 2'h0};
   localparam logic [17:0] A_CTRL        = {IDX_CTRL, 2'h0};
   localparam logic [17:0] A_CMP_CH0     = {IDX_CMP_CH0, 2'h0};
   localparam logic [17:0] A_CMP_CH1     = {IDX_CMP_CH1, 2'h0};
   localparam logic [17:0] A_CNT_CH0     = {IDX_CNT_CH0, 2'h0};
   localparam logic [17:0] A_CNT_CH1     = {IDX_CNT_CH1, 2'h0};
   localparam logic [17:0] A_STATUS      = {IDX_STATUS, 2'h0};
   localparam logic [17:0] A_PORT_DIR    = {IDX_PORT_DIR, 2'h0};
   localparam logic [17:0] A_PORT_LAT    = {IDX_PORT_LAT, 2'h0};
   // reset values and write masks
   localparam logic [7:0]  MODE_RST      = 8'h00;
   localparam logic [7:0]  MODE_WMASK    = 8'hF3;
   localparam logic [7:0]  DIR_RST       = 8'hFF;
   localparam logic [15:0] CMP_ONES      = 16'hFFFF;
   // field positions
   localparam int IN1_LSB  = 6;
   localparam int IN0_LSB  = 4;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_INT = 2;
   localparam int CTRL_OUT = 4;
   // edge and count clock codes
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] CLK_FX    = 2'h0;
   localparam logic [1:0] CLK_DIVA  = 2'h1;
   localparam logic [1:0] CLK_DIVB  = 2'h2;
   localparam logic [1:0] CLK_EXT   = 2'h3;
   // divider exponents per channel
   localparam int DIVA_CH0 = 2;
   localparam int DIVB_CH0 = 8;
   localparam int DIVA_CH1 = 4;
   localparam int DIVB_CH1 = 6;
   localparam int SHARED_PIN_CH0 = 1;
   localparam int SHARED_PIN_CH1 = 6;
   // per channel state
   typedef struct packed {
      logic [7:0]  mode;
      logic [15:0] upCnt;
      logic [15:0] cmpA;
      logic        a1, a2, aLvl;
      logic        b1, b2, bLvl;
      logic        everRun;
      logic        ovf;
      logic        tout;
   } tpe_chan_t;
endpackage

/* File: hw/tpe_timer.sv */
// prescaler, valid edge selector, interval timer and port direction for two counters
// Functional notes
// - reset clears both mode registers to zero
// - bits 7:6 pick second input edge
// - bits 5:4 pick first input edge
// - bits 1:0 pick count clock per counter
// - high input after reset gives first rise
// - restart after stop gives no spurious rise
// - shared pin is input or output
// - reset sets port direction to all ones
// - direction bit zero drives, one floats
// - match clears counter and raises match pulse
// - edge accepted after two equal samples
// - interval overflow only when compare all ones
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module tpe_timer
   import tpe_pkg::*;
#(
   parameter int PINS = 7
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [17:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // timer inputs and port pins
   input  wire logic [1:0]        firstIn,
   input  wire logic [PINS-1:0]   pinIn,
   output logic      [PINS-1:0]   pinOut,
   output logic      [PINS-1:0]   pinOeN,
   // events
   output logic      [1:0]        matchIrq,
   output logic      [1:0]        in1Edge
);
   // *****************************************
   // state and checks
   // *****************************************
   typedef struct packed {
      tpe_chan_t [1:0]  ch;
      logic [7:0]       divCnt;
      logic [7:0]       ctrl;
      logic [7:0]       dir;
      logic [7:0]       lat;
      logic [PINS-1:0]  pOut;
      logic [PINS-1:0]  pOeN;
      logic [1:0]       match;
      logic [1:0]       e1;
      logic             rdy;
      logic             err;
      logic [31:0]      rdat;
   } tpe_state_t;

   tpe_state_t s_q;
   tpe_state_t s_d;
   logic [1:0] tick;
   logic [1:0] rise0;
   logic [1:0] ev0;

   // refuse pin counts that miss the shared pins
   if (PINS <= SHARED_PIN_CH1 || PINS > 8) begin : g_chk
      $error("tpe_timer: PINS must be 7 or 8");
   end

   // *****************************************
   // prescaler ticks
   // *****************************************
   for (genvar c = 0; c < 2; c++) begin : g_tick
      localparam int LA = (c == 0) ? DIVA_CH0 : DIVA_CH1;
      localparam int LB = (c == 0) ? DIVB_CH0 : DIVB_CH1;
      logic [1:0] sel;
      assign sel = s_q.ch[c].mode[1:0];
      // one cycle enable per divided period, fx samples ext mode
      always_comb begin
         if (sel == CLK_DIVA) begin
            tick[c] = &s_q.divCnt[LA-1:0];
         end else if (sel == CLK_DIVB) begin
            tick[c] = &s_q.divCnt[LB-1:0];
         end else begin
            tick[c] = 1'b1;
         end
      end
   end

   // valid edge decode for one selection code
   function automatic logic edgeHit(input logic [1:0] code,
                                    input logic r, input logic f);
      logic hit;
      hit = 1'b0;
      case (code)
         EDGE_FALL: hit = f;
         EDGE_RISE: hit = r;
         EDGE_BOTH: hit = r | f;
         default:   hit = 1'b0; // prohibited code detects nothing
      endcase
      return hit;
   endfunction

   // *****************************************
   // next state
   // *****************************************
   always_comb begin
      logic        acc;
      logic        wr;
      logic        hit;
      logic [31:0] rd;
      logic        run;
      logic        intv;
      logic        useOut;
      logic        chgA;
      logic        chgB;
      logic        ev1;
      logic        cntTick;
      logic        ovfSet;
      logic        ovfClr;
      logic        pinB;
      int          sp;
      acc = 1'b0;
      wr = 1'b0;
      hit = 1'b1;
      rd = 32'h0;
      run = 1'b0;
      intv = 1'b0;
      useOut = 1'b0;
      chgA = 1'b0;
      chgB = 1'b0;
      ev1 = 1'b0;
      cntTick = 1'b0;
      ovfSet = 1'b0;
      ovfClr = 1'b0;
      pinB = 1'b0;
      sp = 0;
      rise0 = 2'h0;
      ev0 = 2'h0;
      s_d = s_q;
      s_d.divCnt = s_q.divCnt + 8'h1;
      // read decode
      if (paddr == A_MODE_CH0) begin
         rd[7:0] = s_q.ch[0].mode;
      end else if (paddr == A_MODE_CH1) begin
         rd[7:0] = s_q.ch[1].mode;
      end else if (paddr == A_CTRL) begin
         rd[7:0] = s_q.ctrl;
      end else if (paddr == A_CMP_CH0) begin
         rd[15:0] = s_q.ch[0].cmpA;
      end else if (paddr == A_CMP_CH1) begin
         rd[15:0] = s_q.ch[1].cmpA;
      end else if (paddr == A_CNT_CH0) begin
         rd[15:0] = s_q.ch[0].upCnt;
      end else if (paddr == A_CNT_CH1) begin
         rd[15:0] = s_q.ch[1].upCnt;
      end else if (paddr == A_STATUS) begin
         rd[1:0] = {s_q.ch[1].ovf, s_q.ch[0].ovf};
      end else if (paddr == A_PORT_DIR) begin
         rd[7:0] = s_q.dir;
      end else if (paddr == A_PORT_LAT) begin
         rd[7:0] = s_q.lat;
      end else begin
         hit = 1'b0;
      end
      // one wait state, answer from flops
      s_d.rdy = psel && penable && !s_q.rdy;
      acc = psel && penable && s_q.rdy;
      wr = acc && pwrite && hit;
      // error flag stands only alongside pready
      s_d.err = s_d.rdy && !hit;
      if (s_d.rdy) begin
         s_d.rdat = pwrite ? 32'h0 : rd;
      end
      // register writes
      if (wr && paddr == A_MODE_CH0) begin
         s_d.ch[0].mode = pwdata[7:0] & MODE_WMASK;
      end
      if (wr && paddr == A_MODE_CH1) begin
         s_d.ch[1].mode = pwdata[7:0] & MODE_WMASK;
      end
      if (wr && paddr == A_CTRL) begin
         s_d.ctrl = pwdata[7:0];
      end
      if (wr && paddr == A_CMP_CH0) begin
         s_d.ch[0].cmpA = pwdata[15:0];
      end
      if (wr && paddr == A_CMP_CH1) begin
         s_d.ch[1].cmpA = pwdata[15:0];
      end
      if (wr && paddr == A_PORT_DIR) begin
         s_d.dir = pwdata[7:0];
      end
      if (wr && paddr == A_PORT_LAT) begin
         s_d.lat = pwdata[7:0];
      end
      // port pins default to latch and direction
      s_d.pOeN = s_q.dir[PINS-1:0];
      s_d.pOut = s_q.lat[PINS-1:0];
      // per channel counting
      for (int c = 0; c < 2; c++) begin
         sp = (c == 0) ? SHARED_PIN_CH0 : SHARED_PIN_CH1;
         run = s_q.ctrl[CTRL_RUN + c];
         intv = s_q.ctrl[CTRL_INT + c];
         useOut = s_q.ctrl[CTRL_OUT + c];
         pinB = pinIn[sp];
         // two samples on the count clock
         if (tick[c]) begin
            s_d.ch[c].a1 = firstIn[c];
            s_d.ch[c].a2 = s_q.ch[c].a1;
            s_d.ch[c].b1 = pinB;
            s_d.ch[c].b2 = s_q.ch[c].b1;
         end
         chgA = tick[c] && s_q.ch[c].a1 == s_q.ch[c].a2
                && s_q.ch[c].a2 != s_q.ch[c].aLvl;
         chgB = tick[c] && s_q.ch[c].b1 == s_q.ch[c].b2
                && s_q.ch[c].b2 != s_q.ch[c].bLvl;
         // level frozen low until first run, tracked silently after
         if ((run || s_q.ch[c].everRun) && chgA) begin
            s_d.ch[c].aLvl = s_q.ch[c].a2;
         end
         if ((run || s_q.ch[c].everRun) && chgB) begin
            s_d.ch[c].bLvl = s_q.ch[c].b2;
         end
         rise0[c] = run && chgA && s_q.ch[c].a2;
         ev0[c] = edgeHit(s_q.ch[c].mode[IN0_LSB +: 2], rise0[c],
                          run && chgA && !s_q.ch[c].a2);
         ev1 = !useOut && edgeHit(s_q.ch[c].mode[IN1_LSB +: 2],
                 run && chgB && s_q.ch[c].b2,
                 run && chgB && !s_q.ch[c].b2);
         s_d.e1[c] = ev1;
         if (run) begin
            s_d.ch[c].everRun = 1'b1;
         end
         // count clock: prescaler tick or first input edge
         if (s_q.ch[c].mode[1:0] == CLK_EXT) begin
            cntTick = run && ev0[c];
         end else begin
            cntTick = run && tick[c];
         end
         s_d.match[c] = 1'b0;
         ovfSet = 1'b0;
         if (!run) begin
            s_d.ch[c].upCnt = 16'h0;
         end else if (cntTick) begin
            if (intv && s_q.ch[c].upCnt == s_q.ch[c].cmpA) begin
               s_d.ch[c].upCnt = 16'h0;
               s_d.match[c] = 1'b1;
               s_d.ch[c].tout = !s_q.ch[c].tout;
               ovfSet = s_q.ch[c].cmpA == CMP_ONES;
            end else begin
               s_d.ch[c].upCnt = s_q.ch[c].upCnt + 16'h1;
               ovfSet = !intv && s_q.ch[c].upCnt == CMP_ONES;
            end
         end
         // write one clears, a new overflow wins
         ovfClr = wr && paddr == A_STATUS && pwdata[c];
         if (ovfClr) begin
            s_d.ch[c].ovf = 1'b0;
         end
         if (ovfSet) begin
            s_d.ch[c].ovf = 1'b1;
         end
         // shared pin carries timer output only when chosen
         if (useOut) begin
            s_d.pOut[sp] = s_q.ch[c].tout | s_q.lat[sp];
         end
      end
      // synchronous reset values
      if (!rst_n) begin
         s_d = '0;
         s_d.ch[0].mode = MODE_RST;
         s_d.ch[1].mode = MODE_RST;
         s_d.dir = DIR_RST;
         s_d.pOeN = '1;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   // outputs straight from flops
   assign prdata   = s_q.rdat;
   assign pready   = s_q.rdy;
   assign pslverr  = s_q.err;
   assign pinOut   = s_q.pOut;
   assign pinOeN   = s_q.pOeN;
   assign matchIrq = s_q.match;
   assign in1Edge  = s_q.e1;

   // *****************************************
   // assertions
   // *****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence seq_stopped_seen;
      s_q.ch[0].everRun && !s_q.ctrl[CTRL_RUN] && s_q.ch[0].a2 == s_q.ch[0].aLvl;
   endsequence

   sequence seq_quiet_start;
      s_q.ctrl[CTRL_RUN] && $stable(s_q.ch[0].a1) && $stable(s_q.ch[0].a2);
   endsequence

   a_mode_reset: assert property ($past(!rst_n) |->
      s_q.ch[0].mode == MODE_RST && s_q.ch[1].mode == MODE_RST)
      else $error("mode registers not cleared by reset");
   a_dir_reset: assert property ($past(!rst_n) |->
      s_q.dir == DIR_RST && &s_q.pOeN)
      else $error("port direction not all ones after reset");
   a_mode_zero_bits: assert property (
      s_q.ch[0].mode[3:2] == 2'h0 && s_q.ch[1].mode[3:2] == 2'h0)
      else $error("mode bits 3:2 not zero");
   a_bad_edge_code: assert property (
      s_q.ch[0].mode[IN0_LSB +: 2] == 2'h2 |-> !ev0[0])
      else $error("prohibited edge code produced an edge");
   a_prescale_gap: assert property (
      s_q.ctrl[CTRL_RUN] && s_q.ch[0].mode[1:0] == CLK_DIVA
      && !(&s_q.divCnt[DIVA_CH0-1:0]) |=> $stable(s_q.ch[0].upCnt))
      else $error("counter moved between prescaler ticks");
   a_ext_count_one: assert property (
      s_q.ctrl[CTRL_RUN] && !s_q.ctrl[CTRL_INT]
      && s_q.ch[0].mode[1:0] == CLK_EXT && ev0[0]
      |=> s_q.ch[0].upCnt == $past(s_q.ch[0].upCnt) + 16'h1)
      else $error("external edge did not count by one");
   a_interval_clear: assert property (
      s_q.ctrl[CTRL_RUN] && s_q.ctrl[CTRL_INT] && tick[0]
      && s_q.ch[0].mode[1:0] != CLK_EXT
      && s_q.ch[0].upCnt == s_q.ch[0].cmpA
      |=> s_q.ch[0].upCnt == 16'h0 && s_q.match[0])
      else $error("interval match did not clear and signal");
   a_interval_ovf: assert property (
      $past(s_q.ctrl[CTRL_INT]) && $rose(s_q.ch[0].ovf)
      |-> $past(s_q.ch[0].cmpA) == CMP_ONES)
      else $error("interval overflow with compare not all ones");
   a_first_rise: assert property (
      (!s_q.ch[1].everRun && !s_q.ctrl[CTRL_RUN + 1]
       && s_q.ch[1].b1 && s_q.ch[1].b2 && !s_q.ch[1].bLvl)
      ##1 (s_q.ctrl[CTRL_RUN + 1] && !s_q.ctrl[CTRL_OUT + 1] && tick[1]
           && s_q.ch[1].b1 && s_q.ch[1].b2 && s_q.ch[1].mode[IN1_LSB])
      |=> s_q.e1[1])
      else $error("high input after reset gave no rise");
   a_restart_quiet: assert property (
      seq_stopped_seen ##1 seq_quiet_start |-> !rise0[0])
      else $error("spurious rise on restart");
   a_shared_excl: assert property (
      s_q.ctrl[CTRL_OUT] |=> !s_q.e1[0])
      else $error("second input edge while pin is output");
   a_dir_drive: assert property (
      psel && penable && pwrite && pready && paddr == A_PORT_DIR
      |=> ##1 s_q.pOeN == $past(pwdata[PINS-1:0], 2))
      else $error("direction write did not reach enables");

endmodule

/* File: verification/tpe_pulse_src.sv */
// external pulse source model driving the timer input pins
`timescale 1ns/100ps
module tpe_pulse_src (
   // clock
   input  wire logic       clk,
   // pin levels
   output logic      [1:0] firstIn,
   output logic      [6:0] pinIn
);
   logic [1:0] secIn;
   logic [6:0] noise;
   // second input of counter 1 sits high out of reset
   initial begin
      firstIn = 2'h0;
      secIn   = 2'h2;
      noise   = 7'h2A;
   end
   // port bits nobody drives keep changing so no stale level passes
   always @(posedge clk) noise <= ~noise;
   assign pinIn = {secIn[1], noise[5:2], secIn[0], noise[0]};
   // ***************************************
   // pulse and level tasks
   // ***************************************
   // high for hi whole cycles, then low for lo cycles
   task automatic pulse(input int ch, input int hi, input int lo);
      @(posedge clk);
      firstIn[ch] <= 1'b1;
      repeat (hi) @(posedge clk);
      firstIn[ch] <= 1'b0;
      repeat (lo) @(posedge clk);
   endtask
   // set a second input level just after an edge
   task automatic setSec(input int ch, input logic v);
      @(posedge clk);
      secIn[ch] <= v;
   endtask
endmodule

/* File: verification/tb_timer_prescale_edge_interval.sv */
// self-checking bench for the prescaler, edge selector and interval timer
`timescale 1ns/100ps
module tb_timer_prescale_edge_interval;
   import tpe_pkg::*;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [1:0]  firstIn, matchIrq, in1Edge;
   logic [6:0]  pinIn, pinOut, pinOeN;
   int          num_errors = 0;
   int          tests_run = 0;
   int          seen;
   tpe_timer #(.PINS(7)) DUT (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .firstIn(firstIn), .pinIn(pinIn), .pinOut(pinOut),
      .pinOeN(pinOeN), .matchIrq(matchIrq), .in1Edge(in1Edge));
   tpe_pulse_src src (.clk(clk), .firstIn(firstIn), .pinIn(pinIn));
   // ***************************************
   // shared tasks
   // ***************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // apb transfer, answer taken at the rising edge that sees pready
   task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) num_errors++;
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [17:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
   task rd(input logic [17:0] a); apb(1'b0, a, 32'h0); endtask
   // count second-input edge pulses of one counter
   task watch(input int ch, input int cyc);
      repeat (cyc) begin
         @(negedge clk);
         if (in1Edge[ch] === 1'b1) seen++;
      end
   endtask
   task toggle(input int ch);
      seen = 0;
      src.setSec(ch, 1'b0);
      watch(ch, 8);
      src.setSec(ch, 1'b1);
      watch(ch, 8);
   endtask
   // cycles between two match pulses
   task gap(input int ch, input int exp);
      int n;
      n = 0;
      while (matchIrq[ch] !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
      if (n >= 2000) num_errors++;
      n = 0;
      do begin @(negedge clk); n++; end while (matchIrq[ch] !== 1'b1 && n < 2000);
      chk(32'(n), 32'(exp));
   endtask
   // ***************************************
   // scenarios
   // ***************************************
   task t_reset;
      chk({25'h0, pinOeN}, 32'h7F);
      chk({25'h0, pinOut}, 32'h0);
      rd(A_MODE_CH0); chk(rdat, 32'h0);
      rd(A_MODE_CH1); chk(rdat, 32'h0);
      rd(A_PORT_DIR); chk(rdat, 32'hFF);
   endtask
   task t_first_rise;
      logic [1:0] code [4];
      int         ex [4];
      code = '{2'h0, 2'h1, 2'h2, 2'h3};
      ex   = '{1, 1, 0, 2};
      wr(A_PORT_DIR, 32'hBF);
      wr(A_MODE_CH1, 32'h40);
      seen = 0;
      wr(A_CTRL, 32'h02);
      watch(1, 8); chk(32'(seen), 32'h1);
      wr(A_CTRL, 32'h00);
      seen = 0;
      wr(A_CTRL, 32'h02);
      watch(1, 8); chk(32'(seen), 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(A_CTRL, 32'h00);
         wr(A_MODE_CH1, {24'h0, code[i], 6'h0});
         wr(A_CTRL, 32'h02);
         toggle(1); chk(32'(seen), 32'(ex[i]));
      end
      wr(A_CTRL, 32'h22);
      toggle(1); chk(32'(seen), 32'h0);
      wr(A_CTRL, 32'h00);
   endtask
   task t_regs;
      wr(A_MODE_CH0, 32'hFF); rd(A_MODE_CH0); chk(rdat, 32'hF3);
      wr(A_MODE_CH0, 32'h00);
      wr(A_PORT_DIR, 32'h55);
      repeat (2) @(negedge clk);
      chk({25'h0, pinOeN}, 32'h55);
      rd(A_PORT_DIR); chk(rdat, 32'h55);
      wr(18'h00010, 32'h1); chk({31'h0, rerr}, 32'h1);
      rd(18'h00010); chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      wr(A_CNT_CH0, 32'h1234); rd(A_CNT_CH0); chk(rdat, 32'h0);
   endtask
   task t_ext_count;
      logic [7:0] code [4];
      int         ex [4];
      code = '{8'h03, 8'h13, 8'h23, 8'h33};
      ex   = '{3, 3, 0, 6};
      for (int i = 0; i < 4; i++) begin
         wr(A_CTRL, 32'h00);
         wr(A_MODE_CH0, {24'h0, code[i]});
         wr(A_CTRL, 32'h01);
         repeat (3) src.pulse(0, 4, 4);
         src.pulse(0, 1, 6);
         rd(A_CNT_CH0); chk(rdat, 32'(ex[i]));
      end
      wr(A_CTRL, 32'h00);
   endtask
   task t_interval;
      int ch [6];
      int md [6];
      int cp [6];
      int ex [6];
      int t;
      logic p;
      ch = '{0, 0, 0, 1, 1, 1};
      md = '{0, 1, 2, 0, 1, 2};
      cp = '{4, 1, 1, 3, 1, 1};
      ex = '{5, 8, 512, 4, 32, 128};
      wr(A_PORT_DIR, 32'hBD);
      wr(A_PORT_LAT, 32'h00);
      for (int i = 0; i < 6; i++) begin
         wr(A_CTRL, 32'h00);
         wr(ch[i] ? A_CMP_CH1 : A_CMP_CH0, 32'(cp[i]));
         wr(ch[i] ? A_MODE_CH1 : A_MODE_CH0, 32'(md[i]));
         wr(A_CTRL, 32'((5 << ch[i]) | (i == 0 ? 16 : 0)));
         gap(ch[i], ex[i]);
         rd(ch[i] ? A_CNT_CH1 : A_CNT_CH0);
         chk({31'h0, rdat <= 32'(cp[i])}, 32'h1);
         if (i == 0) begin
            t = 0;
            p = pinOut[1];
            repeat (10) begin
               @(negedge clk);
               if (pinOut[1] !== p) t++;
               p = pinOut[1];
            end
            chk(32'(t), 32'h2);
         end
      end
      rd(A_STATUS); chk(rdat, 32'h0);
      wr(A_CTRL, 32'h00);
   endtask
   // ***************************************
   // verdict, clock, watchdog and sequence
   // ***************************************
   task results;
      $display("errors=%0d comparisons=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #(20000 * 100);
      num_errors++;
      results();
   end
   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 18'h0; pwdata = 32'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_first_rise();
      t_regs();
      t_ext_count();
      t_interval();
      results();
   end
endmodule
